// [src/ssp_pkg.sv]
// Constants, state layouts and register map for the synchronous slave serial port.
// Assumes a single sys_clk domain; the serial clock is sampled, not used as a clock.
//
// Overview of operation
// - Queued first character loads shifter at once
// - Second character waits; transmit empty flag clear
// - After shift out, reload, then flag empty
// - Transmit flag with enables wakes, requests service
// - Nine bit transmit shifts ninth bit too
// - Continuous receive keeps receiver listening until an overrun
// - Single receive enable starts no receive, but halts transmit
// - Complete character moves into receive buffer
// - Received character sets flag, may wake
// - Receive wake with global enable takes vector
// - Ninth received bit shown in status register
// - Clearing continuous receive clears overrun
// - Runs only in synchronous slave mode
// - Shifters advance only on external serial clock
// - Accept data and clock pins during sleep
// - Service entry at fixed vector address
// - Clock driver off; change leading, valid trailing
// - Receive samples on trailing clock edge
// - Two character FIFO; third sets overrun, blocks
package ssp_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_INT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PIE = 8'h04;
  localparam logic [7:0] ADDR_PIR = 8'h08;
  localparam logic [7:0] ADDR_RX_STAT = 8'h0c;
  localparam logic [7:0] ADDR_PORTC_DIR = 8'h10;
  localparam logic [7:0] ADDR_TX_BUF = 8'h14;
  localparam logic [7:0] ADDR_TX_STAT = 8'h18;
  localparam logic [7:0] ADDR_RX_BUF = 8'h1c;

  // Reset values
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_PIE = 8'h00;
  localparam logic [7:0] RST_RX_STAT = 8'h00;
  localparam logic [7:0] RST_PORTC_DIR = 8'hff;
  localparam logic [7:0] RST_TX_STAT = 8'h02;

  // Field positions
  localparam int GIE_B = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_B = 6;
  localparam int RX_IRQ_ENABLE_B = 5;
  localparam int TX_IRQ_ENABLE_B = 4;
  localparam int PORT_ENABLE_B = 7;
  localparam int RX9_B = 6;
  localparam int SINGLE_RX_ENABLE_B = 5;
  localparam int CONTINUOUS_RX_ENABLE_B = 4;
  localparam int CLOCK_SOURCE_SELECT_B = 7;
  localparam int TX9_B = 6;
  localparam int TRANSMIT_ENABLE_B = 5;
  localparam int SYNC_B = 4;
  localparam int TX_NINTH_BIT_B = 0;

  // Writable bits
  localparam logic [7:0] MASK_RX_STAT = 8'hf8;
  localparam logic [7:0] MASK_TX_STAT = 8'hf5;

  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_9 = 4'h9;
  localparam logic [15:0] ISR_VECTOR = 16'h0004;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] int_ctrl;
    logic [7:0] pie;
    logic [7:0] rx_ctrl;
    logic [7:0] portc_dir;
    logic [7:0] tx_ctrl;
    logic [8:0] hold;
    logic hold_full;
    logic [8:0] transmit_shift_reg;
    logic [3:0] tcnt;
    logic busy;
    logic [8:0] receive_shift_reg;
    logic [3:0] rcnt;
    logic overrun_error;
    logic clk_d;
    logic dat_o;
    logic dat_oe;
    logic ck_oe;
    logic wake;
    logic irq;
    logic [15:0] vec;
  } ssp_state_s;

  typedef struct packed {
    logic [1:0][8:0] mem;
    logic rd;
    logic [1:0] count;
  } ssp_fifo_s;

endpackage : ssp_pkg

// [src/ssp_fifo_if.sv]
// Connection between the port core and its receive FIFO.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
`default_nettype none
interface ssp_fifo_if;
  logic push;
  logic [8:0] push_data;
  logic pop;
  logic [8:0] head;
  logic [1:0] count;
  modport core (output push, output push_data, output pop, input head, input count);
  modport fifo (input push, input push_data, input pop, output head, output count);
endinterface : ssp_fifo_if
`default_nettype wire

// [src/ssp_sync2.sv]
// Two flip-flop synchroniser for asynchronous pin inputs.
// Assumes inputs may change at any time relative to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module ssp_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : ssp_sync2
`default_nettype wire

// [src/ssp_rx_fifo.sv]
// Two entry receive FIFO of nine-bit characters.
// Assumes the core never pushes while full.
`timescale 1ns/10ps
`default_nettype none
module ssp_rx_fifo (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Core side
  ssp_fifo_if.fifo f
);
  import ssp_pkg::*;

  ssp_fifo_s s;
  ssp_fifo_s next_s;

  always_comb begin
    next_s = s;
    if (f.pop && s.count != 2'h0) begin
      next_s.rd = ~s.rd;
    end
    if (f.push && s.count != FIFO_DEPTH) begin
      next_s.mem[s.rd ^ s.count[0]] = f.push_data;
    end
    next_s.count = s.count + {1'b0, f.push && s.count != FIFO_DEPTH}
                   - {1'b0, f.pop && s.count != 2'h0};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign f.head = s.mem[s.rd];
  assign f.count = s.count;
endmodule : ssp_rx_fifo
`default_nettype wire

// [src/ssp_port.sv]
// Synchronous slave serial port: APB registers, transmit and receive shifters.
// Assumes an external master drives the serial clock; it is sampled by sys_clk.
`timescale 1ns/10ps
`default_nettype none
module ssp_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Serial clock pin
  input wire logic serial_clock_in,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  // Serial data pin
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Processor side
  input wire logic cpu_sleep,
  output logic wake_request,
  output logic irq_request,
  output logic [15:0] irq_vector
);
  import ssp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and receive FIFO

  logic [1:0] pins_sync;
  logic s_clk;
  logic s_dat;

  ssp_sync2 #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({serial_clock_in, serial_data_in}),
    .sync_out(pins_sync)
  );

  assign s_clk = pins_sync[1];
  assign s_dat = pins_sync[0];

  ssp_fifo_if fifo_if ();

  ssp_rx_fifo u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .f(fifo_if.fifo)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded controls

  ssp_state_s s;
  ssp_state_s next_s;

  logic slave_on;
  logic tx_mode;
  logic lead_edge;
  logic trail_edge;
  logic [3:0] tx_len;
  logic [3:0] rx_len;
  logic tx_flag;
  logic rx_flag;
  logic apb_done;
  logic tx_done;
  logic rx_done;
  logic tx_buf_wr;

  // Only the slave setting can run; everything else is halted, asleep or not
  assign slave_on = s.rx_ctrl[PORT_ENABLE_B] && s.tx_ctrl[SYNC_B] && !s.tx_ctrl[CLOCK_SOURCE_SELECT_B];
  assign tx_mode = !s.rx_ctrl[CONTINUOUS_RX_ENABLE_B] && !s.rx_ctrl[SINGLE_RX_ENABLE_B];
  assign lead_edge = s_clk && !s.clk_d;
  assign trail_edge = !s_clk && s.clk_d;
  assign tx_len = s.tx_ctrl[TX9_B] ? LEN_9 : LEN_8;
  assign rx_len = s.rx_ctrl[RX9_B] ? LEN_9 : LEN_8;
  assign tx_flag = s.tx_ctrl[TRANSMIT_ENABLE_B] && !s.hold_full;
  assign rx_flag = fifo_if.count != 2'h0;
  assign apb_done = psel && penable && s.pready;
  assign tx_done = slave_on && tx_mode && s.busy && trail_edge && (s.tcnt + 4'h1 == tx_len);
  // Single receive enable is a don't care here: only continuous receive gates
  assign rx_done = slave_on && !tx_mode && s.rx_ctrl[CONTINUOUS_RX_ENABLE_B] && !s.overrun_error && trail_edge
                   && (s.rcnt + 4'h1 == rx_len);
  // Buffer write that may land in the same cycle as a load
  assign tx_buf_wr = apb_done && pwrite && paddr == ADDR_TX_BUF;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    fifo_if.push = 1'b0;
    fifo_if.push_data = '0;
    fifo_if.pop = 1'b0;
    next_s.clk_d = s_clk;
    next_s.ck_oe = 1'b0;

    // Transmit shifter
    if (slave_on && tx_mode && s.busy) begin
      if (trail_edge) begin
        if (tx_done) begin
          next_s.busy = 1'b0;
          next_s.tcnt = 4'h0;
        end else begin
          next_s.tcnt = s.tcnt + 4'h1;
        end
      end else if (lead_edge && s.tcnt != 4'h0) begin
        next_s.dat_o = s.transmit_shift_reg[s.tcnt];
      end
    end
    // Waiting character moves in at once, then the buffer reads empty
    if (slave_on && tx_mode && s.tx_ctrl[TRANSMIT_ENABLE_B] && !next_s.busy && s.hold_full) begin
      next_s.transmit_shift_reg = s.hold;
      next_s.busy = 1'b1;
      next_s.tcnt = 4'h0;
      next_s.hold_full = 1'b0;
      next_s.dat_o = s.hold[0];
    end
    next_s.dat_oe = slave_on && tx_mode && s.tx_ctrl[TRANSMIT_ENABLE_B];

    // Receive shifter
    if (!s.rx_ctrl[CONTINUOUS_RX_ENABLE_B]) begin
      next_s.overrun_error = 1'b0;
      next_s.rcnt = 4'h0;
    end else if (slave_on && !tx_mode && !s.overrun_error && trail_edge) begin
      next_s.receive_shift_reg[s.rcnt] = s_dat;
      if (rx_done) begin
        next_s.rcnt = 4'h0;
        if (fifo_if.count == FIFO_DEPTH) begin
          next_s.overrun_error = 1'b1;
        end else begin
          fifo_if.push = 1'b1;
          fifo_if.push_data = {s.rx_ctrl[RX9_B] & s_dat, next_s.receive_shift_reg[7:0]};
        end
      end else begin
        next_s.rcnt = s.rcnt + 4'h1;
      end
    end

    // APB: one wait state, answer registered
    next_s.pready = psel && penable && !s.pready;
    if (psel && penable && !s.pready) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = '0;
      if (paddr == ADDR_INT_CTRL) begin
        next_s.prdata[7:0] = s.int_ctrl;
      end else if (paddr == ADDR_PIE) begin
        next_s.prdata[7:0] = s.pie;
      end else if (paddr == ADDR_PIR) begin
        next_s.prdata[7:0] = {2'h0, rx_flag, tx_flag, 4'h0};
      end else if (paddr == ADDR_RX_STAT) begin
        next_s.prdata[7:0] = {s.rx_ctrl[7:3], 1'b0, s.overrun_error, fifo_if.head[8]};
      end else if (paddr == ADDR_PORTC_DIR) begin
        next_s.prdata[7:0] = s.portc_dir;
      end else if (paddr == ADDR_TX_BUF) begin
        next_s.prdata = '0;
      end else if (paddr == ADDR_TX_STAT) begin
        next_s.prdata[7:0] = {s.tx_ctrl[7:2], !s.busy, s.tx_ctrl[0]};
      end else if (paddr == ADDR_RX_BUF) begin
        next_s.prdata[7:0] = fifo_if.head[7:0];
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    if (apb_done && pwrite) begin
      if (paddr == ADDR_INT_CTRL) begin
        next_s.int_ctrl = pwdata[7:0];
      end else if (paddr == ADDR_PIE) begin
        next_s.pie = pwdata[7:0];
      end else if (paddr == ADDR_RX_STAT) begin
        next_s.rx_ctrl = pwdata[7:0] & MASK_RX_STAT;
      end else if (paddr == ADDR_PORTC_DIR) begin
        next_s.portc_dir = pwdata[7:0];
      end else if (paddr == ADDR_TX_BUF) begin
        // A write while the holding buffer stays occupied (no load in the same cycle) is dropped
        if (!next_s.hold_full) begin
          next_s.hold = {s.tx_ctrl[TX_NINTH_BIT_B], pwdata[7:0]};
          next_s.hold_full = 1'b1;
        end
      end else if (paddr == ADDR_TX_STAT) begin
        next_s.tx_ctrl = pwdata[7:0] & MASK_TX_STAT;
      end
    end else if (apb_done && paddr == ADDR_RX_BUF) begin
      fifo_if.pop = 1'b1;
    end

    // Wake and service request, as levels
    next_s.wake = s.int_ctrl[PERIPHERAL_IRQ_ENABLE_B] && ((tx_flag && s.pie[TX_IRQ_ENABLE_B])
                  || (rx_flag && s.pie[RX_IRQ_ENABLE_B]));
    next_s.irq = next_s.wake && s.int_ctrl[GIE_B];
    next_s.vec = next_s.irq ? ISR_VECTOR : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.int_ctrl <= RST_INT_CTRL;
      s.pie <= RST_PIE;
      s.rx_ctrl <= RST_RX_STAT;
      s.portc_dir <= RST_PORTC_DIR;
      s.tx_ctrl <= RST_TX_STAT;
    end else begin
      s <= next_s;
    end
  end

  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign serial_clock_out = s.ck_oe;
  assign serial_clock_oe = s.ck_oe;
  assign serial_data_out = s.dat_o;
  assign serial_data_oe = s.dat_oe;
  assign wake_request = s.wake;
  assign irq_request = s.irq;
  assign irq_vector = s.vec;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_load_cond;
    slave_on && tx_mode && s.tx_ctrl[TRANSMIT_ENABLE_B] && !s.busy && s.hold_full;
  endsequence

  sequence s_rx_full_done;
    rx_done && fifo_if.count == FIFO_DEPTH;
  endsequence

  chk_tx_load_now: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_load_cond |=> s.busy && s.tcnt == 4'h0 && s.transmit_shift_reg == $past(s.hold) && (!s.hold_full || $past(tx_buf_wr)))
    else $error("waiting character not moved into the shifter");

  chk_hold_flag_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s.busy && s.hold_full && !tx_done |=> s.hold_full && $stable(s.hold) && !tx_flag)
    else $error("transmit empty flag set while holding a character");

  chk_tx_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_done && s.hold_full && s.tx_ctrl[TRANSMIT_ENABLE_B] |=> s.busy && (tx_flag || $past(tx_buf_wr))
      && s.transmit_shift_reg == $past(s.hold))
    else $error("held character not reloaded after shift out");

  chk_tx_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_flag && s.pie[TX_IRQ_ENABLE_B] && s.int_ctrl[PERIPHERAL_IRQ_ENABLE_B] |=> wake_request ##0 (irq_request == $past(s.int_ctrl[GIE_B])))
    else $error("transmit wake or service request missing");

  chk_rx_push: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_done && fifo_if.count != FIFO_DEPTH && !fifo_if.pop |=> fifo_if.count == $past(fifo_if.count) + 2'h1)
    else $error("completed character not stored");

  chk_rx_flag_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_done && s.pie[RX_IRQ_ENABLE_B] && s.int_ctrl[PERIPHERAL_IRQ_ENABLE_B] && !fifo_if.pop |=> ##1 wake_request)
    else $error("receive wake missing");

  chk_overrun_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rx_full_done |=> s.overrun_error && fifo_if.count == FIFO_DEPTH - {1'b0, $past(fifo_if.pop)}
      ##1 (!s.rx_ctrl[CONTINUOUS_RX_ENABLE_B] || s.overrun_error))
    else $error("overrun not flagged or data overwritten");

  chk_overrun_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !s.rx_ctrl[CONTINUOUS_RX_ENABLE_B] |=> !s.overrun_error)
    else $error("overrun not cleared with continuous receive off");

  chk_vector_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_request |-> irq_vector == 16'h0004 && wake_request)
    else $error("service request without fixed vector");

  chk_clock_drv_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    serial_clock_oe == 1'b0)
    else $error("clock pin driver enabled");

  chk_halt_non_slave: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !slave_on && s.busy |=> $stable(s.tcnt) && $stable(s.transmit_shift_reg))
    else $error("shifter moved outside slave mode");

  // Slave shifting must keep going while the processor sleeps
  chk_sleep_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cpu_sleep && slave_on && tx_mode && s.busy && trail_edge && !tx_done |=> s.tcnt == $past(s.tcnt) + 4'h1)
    else $error("shifter stalled during sleep");

  chk_trail_sample: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s.rx_ctrl[CONTINUOUS_RX_ENABLE_B] && !lead_edge && !trail_edge |=> $stable(s.rcnt))
    else $error("receive count moved without a trailing edge");

endmodule : ssp_port
`default_nettype wire

// [bench/ssp_ext_master.sv]
// Behavioural external synchronous master that clocks the slave serial port.
// Assumes the bench resolves the shared data line and feeds it back as line_d.
`timescale 1ns/10ps
`default_nettype none
module ssp_ext_master (
  // Serial pins
  output logic m_clk,
  output logic m_d,
  output logic m_oe,
  input wire logic line_d
);
  initial begin
    m_clk = 1'b0;
    m_d = 1'b0;
    m_oe = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // One bit per 80 ns clock, LSB first; clock stands low between frames
  task automatic xfer(input logic [8:0] d, input int n, input logic drv, output logic [8:0] q);
    q = 9'h000;
    #3.3;
    m_oe = drv;
    for (int i = 0; i < n; i++) begin
      m_d = d[i];
      m_clk = 1'b1;
      #40;
      m_clk = 1'b0;
      q[i] = line_d;
      #40;
    end
    m_oe = 1'b0;
  endtask : xfer
endmodule : ssp_ext_master
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the synchronous slave serial port.
// Assumes the external master model drives the serial pins; APB master lives here.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ssp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cpu_sleep = 1'b0;
  logic pready, pslverr, sck_out, sck_oe, sd_out, sd_oe, wake_request, irq_request;
  logic [31:0] prdata, rdv;
  logic [15:0] irq_vector;
  logic m_clk, m_d, m_oe, errv;
  logic [8:0] got, e;
  logic [8:0] exp_q[$];
  logic [15:0] rnd = 16'h2f9d;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // Idle data line shows the inverse of the last value, never a stale copy
  wire sck_line = sck_oe ? sck_out : m_clk;
  wire line_d = sd_oe ? sd_out : (m_oe ? m_d : ~m_d);
  logic [7:0] addrs[8] = '{ADDR_INT_CTRL, ADDR_PIE, ADDR_PIR, ADDR_RX_STAT, ADDR_PORTC_DIR, ADDR_TX_BUF,
                           ADDR_TX_STAT, ADDR_RX_BUF};
  logic [7:0] rst_v[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h02, 8'h00};

  ssp_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .serial_clock_in(sck_line), .serial_clock_out(sck_out), .serial_clock_oe(sck_oe),
    .serial_data_in(line_d), .serial_data_out(sd_out), .serial_data_oe(sd_oe), .cpu_sleep(cpu_sleep),
    .wake_request(wake_request), .irq_request(irq_request), .irq_vector(irq_vector));
  ssp_ext_master mst (.m_clk(m_clk), .m_d(m_d), .m_oe(m_oe), .line_d(line_d));

  always #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic final_report();
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : cmp

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask : rd

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (addrs[i]) begin
      rd(addrs[i]);
      cmp("reset value", {24'h000000, rst_v[i]}, rdv);
    end
    rd(8'h20);
    cmp("unmapped error", 32'h1, errv);
    cpu_sleep <= 1'b1;
    wr(ADDR_RX_STAT, 8'h80);
    wr(ADDR_INT_CTRL, 8'hc0);
    wr(ADDR_PIE, 8'h10);
    wr(ADDR_TX_STAT, 8'h30);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      exp_q.push_back({1'b0, rnd[7:0]});
      wr(ADDR_TX_BUF, rnd[7:0]);
    end
    rd(ADDR_PIR);
    cmp("tx flag while held", 32'h0, rdv);
    cmp("wake while held", 32'h0, wake_request);
    for (int i = 0; i < 2; i++) begin
      mst.xfer(9'h000, 8, 1'b0, got);
      e = exp_q.pop_front();
      cmp("tx char", e, got);
      rd(ADDR_PIR);
      cmp("tx flag after shift", 32'h10, rdv);
      cmp("wake irq vector", 32'h00030004, {14'h0, wake_request, irq_request, irq_vector});
    end
    rd(ADDR_TX_STAT);
    cmp("shift empty", 32'h32, rdv);
    cmp("clock pin driven", 32'h0, {sck_oe, sck_out});
    rnd = lfsr(rnd);
    wr(ADDR_TX_STAT, 8'h71);
    wr(ADDR_TX_BUF, rnd[7:0]);
    mst.xfer(9'h000, 9, 1'b0, got);
    cmp("nine bit tx", {1'b1, rnd[7:0]}, got);
    // Receive: third character overruns a full FIFO
    wr(ADDR_TX_STAT, 8'h10);
    wr(ADDR_PIE, 8'h20);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      wr(ADDR_RX_STAT, (i == 1) ? 8'hb0 : 8'h90);
      if (i < 2) exp_q.push_back({1'b0, rnd[7:0]});
      mst.xfer({1'b0, rnd[7:0]}, 8, 1'b1, got);
      cmp("data pin released", 32'h0, sd_oe);
    end
    rd(ADDR_PIR);
    cmp("rx flag", 32'h20, rdv);
    cmp("rx wake irq vector", 32'h00030004, {14'h0, wake_request, irq_request, irq_vector});
    rd(ADDR_RX_STAT);
    cmp("overrun", 32'h2, rdv & 32'h2);
    for (int i = 0; i < 2; i++) begin
      rd(ADDR_RX_BUF);
      e = exp_q.pop_front();
      cmp("rx char", {24'h000000, e[7:0]}, rdv);
    end
    rd(ADDR_PIR);
    cmp("rx flag drained", 32'h0, rdv);
    wr(ADDR_RX_STAT, 8'h80);
    rd(ADDR_RX_STAT);
    cmp("overrun cleared", 32'h80, rdv & 32'hfe);
    // Master-clock mode must not receive
    wr(ADDR_TX_STAT, 8'h90);
    wr(ADDR_RX_STAT, 8'h90);
    rnd = lfsr(rnd);
    mst.xfer({1'b0, rnd[7:0]}, 8, 1'b1, got);
    rd(ADDR_PIR);
    cmp("halted outside slave", 32'h0, rdv);
    wr(ADDR_TX_STAT, 8'h10);
    wr(ADDR_RX_STAT, 8'hd0);
    rnd = lfsr(rnd);
    mst.xfer({1'b1, rnd[7:0]}, 9, 1'b1, got);
    rd(ADDR_RX_STAT);
    cmp("ninth bit status", 32'hd1, rdv);
    rd(ADDR_RX_BUF);
    cmp("nine bit rx low", {24'h000000, rnd[7:0]}, rdv);
    final_report();
  end
endmodule : testbench
`default_nettype wire
